// ---- fsw_defines.vh ----
/*
 fault supervisor constants: timing, pulldown codes, overcurrent modes.
 assumes inclusion by bare name from the supervisor module.
*/
`ifndef FSW_DEFINES_VH
`define FSW_DEFINES_VH

// overcurrent response modes
`define FSW_OC_LATCHED   2'h0
`define FSW_OC_CYCLE     2'h1
`define FSW_OC_WARNING   2'h2
`define FSW_OC_DISABLED  2'h3

// gate pulldown kinds reported on pd_kind_q
`define FSW_PD_NONE      2'h0
`define FSW_PD_NORMAL    2'h1
`define FSW_PD_OVERCUR   2'h2
`define FSW_PD_SEMI      2'h3

// power states
`define FSW_ST_SLEEP     2'h0
`define FSW_ST_WAKE      2'h1
`define FSW_ST_STANDBY   2'h2
`define FSW_ST_OPERATE   2'h3

// wake delay in microseconds and derived cycles at 40 MHz
`define FSW_WAKE_US      1
`define FSW_CLK_MHZ      40
`define FSW_WAKE_CYC     16'h0028

// watchdog window bounds in cycles (implementer values)
`define FSW_WD_LOWER     16'h0400
`define FSW_WD_UPPER     16'h4000

`endif

// ---- fsw_supervisor.v ----
/*
 fault supervisor: window watchdog, fault response mapping and power
 state sequencing for a multi-channel gate driver.
 assumes all inputs synchronous to sys_clk; fault detectors give levels;
 frame_error_pulse and clear_fault_command are one-cycle pulses.
*/
`timescale 1ns/10ps
`default_nettype none
`include "fsw_defines.vh"

module fsw_supervisor #(
    parameter        HW_VARIANT = 0,
    parameter [15:0] WD_LOWER   = `FSW_WD_LOWER,
    parameter [15:0] WD_UPPER   = `FSW_WD_UPPER
) (
    input  wire       sys_clk,
    input  wire       srst,
    input  wire       sleep_input,
    input  wire       logic_supply_ok,
    input  wire       power_supply_ok,
    input  wire       watchdog_enable_bit,
    input  wire       watchdog_toggle_bit,
    input  wire       watchdog_latch_mode,
    input  wire       driver_off_pin,
    input  wire       driver_enable_bit,
    input  wire       clear_fault_command,
    input  wire       frame_error_pulse,
    input  wire       overcurrent_detect,
    input  wire [1:0] overcurrent_mode,
    input  wire [3:0] overcurrent_pulldown_setting,
    input  wire       pwm_edge,
    input  wire       thermal_shutdown_detect,
    input  wire       thermal_warning_detect,
    output reg        watchdog_fault_flag,
    output reg        frame_error_flag,
    output reg        overcurrent_status_bits,
    output reg        shutdown_flag,
    output reg        overtemperature_warning_flag,
    output reg        warning_summary,
    output reg        fault_output_n,
    output reg        gate_enable,
    output reg  [1:0] pd_kind_q,
    output reg  [3:0] pd_current_q,
    output reg        charge_pump_en,
    output reg        current_sense_en,
    output reg        core_active,
    output reg  [1:0] power_state_q
);

    localparam [15:0] WAKE_CYC = `FSW_WAKE_CYC;

    reg  [1:0]  state_d;
    reg  [15:0] wake_cnt_q;
    reg  [15:0] wd_cnt_q;
    reg         wd_tog_q;
    reg         wd_trip_q;   // watchdog pulldown active
    reg         oc_trip_q;   // overcurrent pulldown active
    reg         wd_warn_q;
    reg         oc_warn_q;
    wire        in_sleep;
    wire        leave_rst;
    wire        wd_svc;
    wire        wd_early;
    wire        wd_expire;
    wire        wd_event;
    wire        oc_hit;
    wire        oc_act;
    wire        drv_allowed;
    reg  [15:0] wake_cnt_d;
    reg  [15:0] wd_cnt_d;
    reg         warn_d;
    reg         fault_n_d;
    reg         gate_en_d;
    reg  [1:0]  pd_kind_d;
    reg         pump_d;

    assign in_sleep  = ~sleep_input | ~logic_supply_ok;
    // leaving sleep passes through wake state, where the watchdog and fault latches reset
    assign leave_rst = srst | (power_state_q == `FSW_ST_SLEEP)
                       | (power_state_q == `FSW_ST_WAKE);

    assign wd_svc    = watchdog_enable_bit &
                       (watchdog_toggle_bit != wd_tog_q);
    assign wd_early  = wd_svc & (wd_cnt_q < WD_LOWER);
    // a service at the upper bound is already late
    assign wd_expire = watchdog_enable_bit &
                       (wd_cnt_q >= WD_UPPER);
    assign wd_event  = wd_early | wd_expire;

    assign oc_hit = overcurrent_detect &
                    (overcurrent_mode != `FSW_OC_DISABLED);
    assign oc_act = oc_hit & ((overcurrent_mode == `FSW_OC_LATCHED) |
                              (overcurrent_mode == `FSW_OC_CYCLE));

    // hardware variant needs no enable bit and has no host
    assign drv_allowed = (power_state_q == `FSW_ST_OPERATE) &
                         power_supply_ok & ~driver_off_pin &
                         ((HW_VARIANT != 0) | driver_enable_bit);

    always @* begin
        state_d = power_state_q;
        case (power_state_q)
            `FSW_ST_SLEEP: begin
                state_d = `FSW_ST_WAKE;
            end
            `FSW_ST_WAKE: begin
                if (wake_cnt_q >= WAKE_CYC - 16'h0001) begin
                    state_d = `FSW_ST_STANDBY;
                end
            end
            `FSW_ST_STANDBY: begin
                if (power_supply_ok) begin
                    state_d = `FSW_ST_OPERATE;
                end
            end
            default: begin
                if (!power_supply_ok) begin
                    state_d = `FSW_ST_STANDBY;
                end
            end
        endcase
        if (in_sleep) begin
            state_d = `FSW_ST_SLEEP;
        end
    end

    always @* begin
        wake_cnt_d = 16'h0000;
        if (power_state_q == `FSW_ST_WAKE) begin
            wake_cnt_d = wake_cnt_q + 16'h0001;
        end
    end

    always @(posedge sys_clk) begin
        if (srst) begin
            power_state_q <= `FSW_ST_SLEEP;
            wake_cnt_q    <= 16'h0000;
        end else begin
            power_state_q <= state_d;
            wake_cnt_q    <= wake_cnt_d;
        end
    end

    // counter held at zero while disabled, saturates at the top
    always @* begin
        wd_cnt_d = wd_cnt_q;
        if (!watchdog_enable_bit || wd_svc || wd_event) begin
            wd_cnt_d = 16'h0000;
        end else if (wd_cnt_q != 16'hffff) begin
            wd_cnt_d = wd_cnt_q + 16'h0001;
        end
    end

    always @(posedge sys_clk) begin
        if (leave_rst) begin
            wd_cnt_q <= 16'h0000;
            wd_tog_q <= 1'b0;
        end else begin
            wd_cnt_q <= wd_cnt_d;
            wd_tog_q <= watchdog_toggle_bit;
        end
    end

    // set wins over clear on every sticky flag
    always @(posedge sys_clk) begin
        if (leave_rst) begin
            watchdog_fault_flag <= 1'b0;
            wd_trip_q           <= 1'b0;
            wd_warn_q           <= 1'b0;
        end else if (wd_event) begin
            watchdog_fault_flag <= 1'b1;
            wd_trip_q           <= watchdog_latch_mode;
            wd_warn_q           <= ~watchdog_latch_mode;
        end else if (clear_fault_command) begin
            watchdog_fault_flag <= 1'b0;
            wd_trip_q           <= 1'b0;
            wd_warn_q           <= 1'b0;
        end
    end

    always @(posedge sys_clk) begin
        if (leave_rst) begin
            frame_error_flag <= 1'b0;
        end else if (frame_error_pulse) begin
            frame_error_flag <= 1'b1;
        end else if (clear_fault_command) begin
            frame_error_flag <= 1'b0;
        end
    end

    // cycle mode: the next pwm edge re-arms the drivers, status stays
    always @(posedge sys_clk) begin
        if (leave_rst) begin
            overcurrent_status_bits <= 1'b0;
            oc_trip_q               <= 1'b0;
            oc_warn_q               <= 1'b0;
        end else begin
            if (oc_hit) begin
                overcurrent_status_bits <= 1'b1;
            end else if (clear_fault_command) begin
                overcurrent_status_bits <= 1'b0;
            end
            if (oc_act) begin
                oc_trip_q <= 1'b1;
            end else if (clear_fault_command) begin
                oc_trip_q <= 1'b0;
            end else if (pwm_edge &&
                         overcurrent_mode == `FSW_OC_CYCLE) begin
                oc_trip_q <= 1'b0;
            end
            if (oc_hit && overcurrent_mode == `FSW_OC_WARNING) begin
                oc_warn_q <= 1'b1;
            end else if (clear_fault_command) begin
                oc_warn_q <= 1'b0;
            end
        end
    end

    always @(posedge sys_clk) begin
        if (leave_rst) begin
            shutdown_flag                <= 1'b0;
            overtemperature_warning_flag <= 1'b0;
        end else begin
            if (thermal_shutdown_detect) begin
                shutdown_flag <= 1'b1;
            end else if (clear_fault_command) begin
                shutdown_flag <= 1'b0;
            end
            if (thermal_warning_detect) begin
                overtemperature_warning_flag <= 1'b1;
            end else if (clear_fault_command) begin
                overtemperature_warning_flag <= 1'b0;
            end
        end
    end

    // next values of the outputs, from the current state of the latches
    always @* begin
        warn_d    = wd_warn_q | oc_warn_q |
                    overtemperature_warning_flag;
        fault_n_d = ~(wd_trip_q | oc_trip_q | shutdown_flag);
        pump_d    = (power_state_q == `FSW_ST_OPERATE) &
                    power_supply_ok & ~shutdown_flag;
        gate_en_d = 1'b0;
        pd_kind_d = `FSW_PD_NORMAL;
        // passive pulldown in sleep reported as semi-active too
        if (leave_rst || shutdown_flag) begin
            pd_kind_d = `FSW_PD_SEMI;
        end else if (oc_trip_q) begin
            pd_kind_d = `FSW_PD_OVERCUR;
        end else if (wd_trip_q || !drv_allowed) begin
            pd_kind_d = `FSW_PD_NORMAL;
        end else begin
            gate_en_d = 1'b1;
            pd_kind_d = `FSW_PD_NONE;
        end
    end

    always @(posedge sys_clk) begin
        if (srst) begin
            warning_summary  <= 1'b0;
            fault_output_n   <= 1'b1;
            gate_enable      <= 1'b0;
            pd_kind_q        <= `FSW_PD_SEMI;
            pd_current_q     <= 4'h0;
            charge_pump_en   <= 1'b0;
            current_sense_en <= 1'b0;
            core_active      <= 1'b0;
        end else begin
            warning_summary  <= warn_d;
            fault_output_n   <= fault_n_d;
            gate_enable      <= gate_en_d;
            pd_kind_q        <= pd_kind_d;
            pd_current_q     <= overcurrent_pulldown_setting;
            charge_pump_en   <= pump_d;
            current_sense_en <= pump_d;
            core_active      <= ~leave_rst;
        end
    end

endmodule
`default_nettype wire

// ---- fsw_sup_chk.sv ----
/* port checker for the fault supervisor.
 assumes it is bound onto the supervisor; one clock, sync reset. */
`timescale 1ns/10ps
`default_nettype none
module fsw_sup_chk (
    input wire       sys_clk,
    input wire       srst,
    input wire       watchdog_enable_bit,
    input wire       watchdog_latch_mode,
    input wire       driver_off_pin,
    input wire       clear_fault_command,
    input wire       frame_error_pulse,
    input wire       thermal_shutdown_detect,
    input wire       watchdog_fault_flag,
    input wire       frame_error_flag,
    input wire       shutdown_flag,
    input wire       fault_output_n,
    input wire       gate_enable,
    input wire       charge_pump_en,
    input wire       current_sense_en,
    input wire       core_active,
    input wire [1:0] pd_kind_q,
    input wire [3:0] pd_current_q,
    input wire [3:0] overcurrent_pulldown_setting,
    input wire [1:0] power_state_q
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    property p_frame;
        frame_error_pulse && power_state_q[1] |=> frame_error_flag; endproperty
    a_frame: assert property (p_frame) else $error("frame flag");
    property p_sd;
        thermal_shutdown_detect && power_state_q[1] |=> shutdown_flag; endproperty
    a_sd: assert property (p_sd) else $error("shutdown flag");
    property p_pump;
        shutdown_flag ##1 shutdown_flag |-> !charge_pump_en; endproperty
    a_pump: assert property (p_pump) else $error("pump on");
    property p_driver_off_pin;
        driver_off_pin |=> !gate_enable; endproperty
    a_driver_off_pin: assert property (p_driver_off_pin) else $error("gate on");
    property p_wdidle;
        !watchdog_enable_bit [*3] |-> !$rose(watchdog_fault_flag); endproperty
    a_wdidle: assert property (p_wdidle) else $error("idle wd");
    property p_wdlatch; $rose(watchdog_fault_flag) && watchdog_latch_mode
        |=> !fault_output_n; endproperty
    a_wdlatch: assert property (p_wdlatch) else $error("wd fault");
    property p_clear; clear_fault_command && !frame_error_pulse
        && power_state_q[1] |=> !frame_error_flag; endproperty
    a_clear: assert property (p_clear) else $error("clear");
    property p_standby;
        (power_state_q != 2'h3) [*3] |-> !gate_enable; endproperty
    a_standby: assert property (p_standby) else $error("standby");
    property p_sense;
        shutdown_flag ##1 shutdown_flag |-> !current_sense_en; endproperty
    a_sense: assert property (p_sense) else $error("sense on");
    property p_pdsemi;
        shutdown_flag |=> pd_kind_q == 2'h3; endproperty
    a_pdsemi: assert property (p_pdsemi) else $error("pd kind");
    property p_pdcur; !$past(srst)
        |-> pd_current_q == $past(overcurrent_pulldown_setting); endproperty
    a_pdcur: assert property (p_pdcur) else $error("pd current");
    property p_core;
        power_state_q[1] |=> core_active; endproperty
    a_core: assert property (p_core) else $error("core idle");
endmodule
bind fsw_supervisor fsw_sup_chk u_fsw_sup_chk (.*);
`default_nettype wire

// ---- fsw_host.sv ----
/* host model: flips the watchdog toggle bit after a commanded wait.
 assumes svc_go is a one-cycle pulse from the bench. */
`timescale 1ns/10ps
`default_nettype none
module fsw_host (
    input  wire       sys_clk,
    input  wire       svc_go,
    input  wire [7:0] svc_wait,
    output reg        watchdog_toggle_bit = 1'b0
);
    reg [7:0] cnt_q = 8'h00;
    // wait sets where in the window the service lands: inside it, or early on purpose
    always @(posedge sys_clk) begin
        if (svc_go)
            cnt_q <= svc_wait;
        else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
            if (cnt_q == 8'h01)
                watchdog_toggle_bit <= ~watchdog_toggle_bit;
        end
    end
endmodule
`default_nettype wire

// ---- fsw_tb.sv ----
/* bench for the fault supervisor: drives at the falling edge, queues
 expected outputs for a monitor. assumes host model and checker. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin \
    n_mismatch++; $display("FAIL %0t got %h want %h", $time, a, e); end end
module tb;
    localparam [8:0] BASE = 9'h007;
    logic sys_clk = 1'b0, srst = 1'b1, sleep_input = 1'b1, pwm_edge = 1'b0;
    logic logic_supply_ok = 1'b1, power_supply_ok = 1'b1, chk = 1'b0;
    logic watchdog_enable_bit = 1'b0, watchdog_latch_mode = 1'b0;
    logic driver_off_pin = 1'b0, driver_enable_bit = 1'b0, svc_go = 1'b0;
    logic clear_fault_command = 1'b0, frame_error_pulse = 1'b0;
    logic overcurrent_detect = 1'b0, thermal_shutdown_detect = 1'b0;
    logic thermal_warning_detect = 1'b0;
    logic [1:0] overcurrent_mode = 2'h0;
    logic [3:0] overcurrent_pulldown_setting = 4'h0;
    logic [7:0] svc_wait = 8'h00;
    wire watchdog_toggle_bit, watchdog_fault_flag, frame_error_flag;
    wire overcurrent_status_bits, shutdown_flag, warning_summary;
    wire overtemperature_warning_flag, fault_output_n, gate_enable;
    wire charge_pump_en, current_sense_en, core_active;
    wire [1:0] pd_kind_q, power_state_q;
    wire [3:0] pd_current_q;
    wire [8:0] obs = {watchdog_fault_flag, frame_error_flag,
        overcurrent_status_bits, shutdown_flag, overtemperature_warning_flag,
        warning_summary, fault_output_n, gate_enable, charge_pump_en};
    logic [8:0] exp_q[$];
    logic [8:0] e;
    logic [8:0] ftab [7] = '{9'h087, 9'h01f, 9'h020, 9'h041, 9'h041,
        9'h04f, 9'h007};
    logic [31:0] seed = 32'h0000001c;
    int checked = 0, n_mismatch = 0;
    fsw_supervisor #(.WD_LOWER(16'h0018), .WD_UPPER(16'h0040))
        u_fsw_supervisor (.*);
    fsw_host u_fsw_host (.sys_clk(sys_clk), .svc_go(svc_go),
        .svc_wait(svc_wait), .watchdog_toggle_bit(watchdog_toggle_bit));
    always #12.5 sys_clk = ~sys_clk;
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    task automatic conclude;
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // outputs settle two edges after a cause; the monitor sees pre-edge
    // values, so look four edges later
    task automatic note(input logic [8:0] v);
        repeat (4) @(negedge sys_clk);
        exp_q.push_back(v);
        chk = 1'b1;
        @(negedge sys_clk) chk = 1'b0;
    endtask
    task automatic pulse(ref logic s);
        @(negedge sys_clk) s = 1'b1;
        @(negedge sys_clk) s = 1'b0;
    endtask
    task automatic wait_st(input logic [1:0] s);
        int k;
        for (k = 0; k < 200 && power_state_q !== s; k++) @(negedge sys_clk);
        if (k == 200) begin
            n_mismatch++;
            conclude;
        end
    endtask
    always @(posedge sys_clk) begin
        if (chk) begin
            e = exp_q.pop_front();
            `CHK(obs, e)
        end
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        conclude;
    end
    initial begin
        repeat (12) @(negedge sys_clk);
        srst = 1'b0;
        wait_st(2'h3);
        note(9'h005);
        driver_enable_bit = 1'b1;
        note(BASE);
        driver_off_pin = 1'b1;
        note(9'h005);
        driver_off_pin = 1'b0;
        for (int i = 0; i < 7; i++) begin
            seed = xs(seed);
            overcurrent_pulldown_setting = seed[3:0];
            overcurrent_mode = i[1:0] + 2'h1;
            {frame_error_pulse, thermal_warning_detect, thermal_shutdown_detect,
                overcurrent_detect} = (i < 3) ? 4'h8 >> i : 4'h1;
            @(negedge sys_clk) frame_error_pulse = 1'b0;
            note(ftab[i]);
            {thermal_warning_detect, thermal_shutdown_detect} = 2'h0;
            overcurrent_detect = 1'b0;
            pulse(clear_fault_command);
            note(BASE);
        end
        overcurrent_mode = 2'h1;
        pulse(overcurrent_detect);
        pulse(pwm_edge);
        note(9'h047);
        pulse(clear_fault_command);
        note(BASE);
        watchdog_latch_mode = 1'b1;
        watchdog_enable_bit = 1'b1;
        svc_wait = 8'h1e;
        pulse(svc_go);
        repeat (30) @(negedge sys_clk);
        note(BASE);
        svc_wait = 8'h02;
        pulse(svc_go);
        note(9'h101);
        pulse(clear_fault_command);
        note(BASE);
        watchdog_latch_mode = 1'b0;
        repeat (80) @(negedge sys_clk);
        note(9'h10f);
        watchdog_enable_bit = 1'b0;
        pulse(clear_fault_command);
        note(BASE);
        pulse(frame_error_pulse);
        sleep_input = 1'b0;
        power_supply_ok = 1'b0;
        repeat (4) @(negedge sys_clk);
        sleep_input = 1'b1;
        wait_st(2'h2);
        note(9'h004);
        power_supply_ok = 1'b1;
        wait_st(2'h3);
        note(BASE);
        conclude;
    end
endmodule
`default_nettype wire
